// ===== pkg/dpsem_pkg.sv
// Constants and types shared by the dual-port semaphore host controller
package dpsem_pkg;
	// ----------------------------------------
	// Widths and addresses
	// ----------------------------------------
	localparam int ADDR_W = 13;
	localparam int DATA_W = 18;
	localparam int CNT_W = 4;
	localparam logic [12:0] MBX_LEFT_ADDR = 13'h1ffe;
	localparam logic [12:0] MBX_RIGHT_ADDR = 13'h1fff;
	localparam logic [9:0] SEM_UPPER_ADDR = 10'h000;
	// ----------------------------------------
	// Command kinds
	// ----------------------------------------
	localparam logic [1:0] CMD_MEM_RD = 2'h0;
	localparam logic [1:0] CMD_MEM_WR = 2'h1;
	localparam logic [1:0] CMD_SEM_RD = 2'h2;
	localparam logic [1:0] CMD_SEM_WR = 2'h3;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 5;
	localparam int T_BAA_NS = 20;
	localparam int T_ACC_NS = 20;
	localparam int T_WP_NS = 15;
	localparam int T_WH_NS = 15;
	localparam int SYNC_CYC = 4;
	localparam int BAA_CYC = (T_BAA_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WH_CYC = (T_WH_NS + CLK_NS - 1) / CLK_NS;
	localparam int SET_CYC = BAA_CYC + SYNC_CYC;
	localparam int RD_CYC = ACC_CYC + SYNC_CYC;
	// ----------------------------------------
	// Access sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_INIT,
		ST_IDLE,
		ST_SETUP,
		ST_STALL,
		ST_HOLD,
		ST_PULSE,
		ST_RECOVER
	} dpsem_state_t;
endpackage

// ===== core/dpsem_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dpsem_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic out_q;
			always_ff @(posedge clk_i)
			begin
				if (!rst_n_i)
				begin
					s1_q <= INIT[g];
					s2_q <= INIT[g];
					s3_q <= INIT[g];
					out_q <= INIT[g];
				end
				else if (en_i)
				begin
					s1_q <= d_i[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// A change counts once the second and third stage agree
					if (s2_q == s3_q)
						out_q <= s3_q;
				end
			end
			assign q_o[g] = out_q;
		end
	endgenerate
endmodule // dpsem_sync
`default_nettype wire

// ===== core/dpsem_ctrl.sv
// Host-side port controller for a dual-port RAM with busy, mailbox and semaphores
// How it works
// - In slave mode host holds busy high, or low to block writes.
// - Outside slave mode host stalls a memory write while busy is low, until busy returns high.
// - Busy from depth-cascaded arrays is combined with an AND.
// - Semaphore access keeps chip enable high and semaphore select low.
// - Host clears its own mailbox flag after power-up.
`timescale 1ns/1ps
`default_nettype none
module dpsem_ctrl #(
	parameter bit IS_LEFT = 1'b1,
	parameter int NBUSY = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic slave_mode_i,
	input wire logic block_writes_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic [1:0] cmd_kind_i,
	input wire logic [12:0] cmd_addr_i,
	input wire logic [17:0] cmd_wdata_i,
	output logic rsp_valid_o,
	output logic [17:0] rsp_rdata_o,
	output logic rsp_contention_o,
	output logic mbx_irq_o,
	output logic ce_n_o,
	output logic rw_n_o,
	output logic oe_n_o,
	output logic token_space_select_n_o,
	output logic [12:0] addr_o,
	input wire logic [17:0] data_i,
	output logic [17:0] data_o,
	output logic data_oe_o,
	input wire logic [NBUSY-1:0] contention_flag_i,
	output logic [NBUSY-1:0] contention_flag_o,
	output logic [NBUSY-1:0] contention_flag_oe_o,
	input wire logic mailbox_irq_n_i
);
	localparam logic [12:0] OWN_MBX = IS_LEFT ? dpsem_pkg::MBX_LEFT_ADDR
		: dpsem_pkg::MBX_RIGHT_ADDR;
	localparam int SW = dpsem_pkg::DATA_W + NBUSY + 1;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [SW-1:0] sync_q;
	logic [17:0] data_s;
	logic [NBUSY-1:0] busy_s;
	logic irq_n_s;
	logic busy_all;

	dpsem_sync #(
		.W(SW),
		.INIT({SW{1'b1}})
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.en_i(en_i),
		.d_i({mailbox_irq_n_i, contention_flag_i, data_i}),
		.q_o(sync_q)
	);

	assign data_s = sync_q[17:0];
	assign busy_s = sync_q[SW-2:dpsem_pkg::DATA_W];
	assign irq_n_s = sync_q[SW-1];
	assign busy_all = &busy_s;
	assign mbx_irq_o = ~irq_n_s;

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	dpsem_pkg::dpsem_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [1:0] kind_q, kind_d;
	logic [12:0] addr_q, addr_d;
	logic [17:0] wdata_q, wdata_d;
	logic init_done_q, init_done_d;
	logic cont_q, cont_d;
	logic is_sem;
	logic is_wr;
	logic busy_ok;

	assign is_sem = kind_q[1];
	assign is_wr = kind_q[0];
	// Semaphore space has no arbitration; slave parts are steered by our own drive
	assign busy_ok = slave_mode_i || is_sem || busy_all;
	assign cmd_ready_o = (st_q == dpsem_pkg::ST_IDLE);

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q + 4'h1;
		kind_d = kind_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		init_done_d = init_done_q;
		cont_d = cont_q;
		case (st_q)
			dpsem_pkg::ST_INIT:
			begin
				// Own mailbox read clears our flag from its unknown power-up state
				kind_d = dpsem_pkg::CMD_MEM_RD;
				addr_d = OWN_MBX;
				cnt_d = 4'h0;
				st_d = dpsem_pkg::ST_SETUP;
			end
			dpsem_pkg::ST_IDLE:
			begin
				cnt_d = 4'h0;
				cont_d = 1'b0;
				if (cmd_valid_i)
				begin
					kind_d = cmd_kind_i;
					// Semaphores decode only the three low address bits
					addr_d = cmd_kind_i[1] ? {dpsem_pkg::SEM_UPPER_ADDR, cmd_addr_i[2:0]}
						: cmd_addr_i;
					wdata_d = cmd_kind_i[1] ? {17'h00000, cmd_wdata_i[0]} : cmd_wdata_i;
					st_d = dpsem_pkg::ST_SETUP;
				end
			end
			dpsem_pkg::ST_SETUP:
			begin
				if (!busy_all)
					cont_d = 1'b1;
				if (!is_wr && cnt_q == 4'(dpsem_pkg::RD_CYC - 1))
				begin
					st_d = dpsem_pkg::ST_RECOVER;
				end
				else if (is_wr && cnt_q == 4'(dpsem_pkg::SET_CYC - 1))
				begin
					cnt_d = 4'h0;
					st_d = busy_ok ? dpsem_pkg::ST_PULSE : dpsem_pkg::ST_STALL;
				end
			end
			dpsem_pkg::ST_STALL:
			begin
				cnt_d = 4'h0;
				if (busy_all)
					st_d = dpsem_pkg::ST_HOLD;
			end
			dpsem_pkg::ST_HOLD:
			begin
				if (!busy_ok)
				begin
					cnt_d = 4'h0;
					st_d = dpsem_pkg::ST_STALL;
				end
				else if (cnt_q == 4'(dpsem_pkg::WH_CYC - 1))
				begin
					cnt_d = 4'h0;
					st_d = dpsem_pkg::ST_PULSE;
				end
			end
			dpsem_pkg::ST_PULSE:
			begin
				if (cnt_q == 4'(dpsem_pkg::WP_CYC - 1))
					st_d = dpsem_pkg::ST_RECOVER;
			end
			dpsem_pkg::ST_RECOVER:
			begin
				init_done_d = 1'b1;
				st_d = dpsem_pkg::ST_IDLE;
			end
			default:
			begin
				st_d = dpsem_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st_q <= dpsem_pkg::ST_INIT;
			cnt_q <= 4'h0;
			kind_q <= dpsem_pkg::CMD_MEM_RD;
			addr_q <= 13'h0000;
			wdata_q <= 18'h00000;
			init_done_q <= 1'b0;
			cont_q <= 1'b0;
		end
		else if (en_i)
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			kind_q <= kind_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			init_done_q <= init_done_d;
			cont_q <= cont_d;
		end
	end

	// ----------------------------------------
	// Registered pin drive
	// ----------------------------------------
	logic active_d;

	assign active_d = (st_d == dpsem_pkg::ST_SETUP) || (st_d == dpsem_pkg::ST_STALL)
		|| (st_d == dpsem_pkg::ST_HOLD) || (st_d == dpsem_pkg::ST_PULSE);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ce_n_o <= 1'b1;
			rw_n_o <= 1'b1;
			oe_n_o <= 1'b1;
			token_space_select_n_o <= 1'b1;
			addr_o <= 13'h0000;
			data_o <= 18'h00000;
			data_oe_o <= 1'b0;
		end
		else if (en_i)
		begin
			ce_n_o <= !(active_d && !kind_d[1]);
			token_space_select_n_o <= !(active_d && kind_d[1]);
			// Output enable drops between reads so a semaphore latch can refresh
			oe_n_o <= !(active_d && !kind_d[0]);
			rw_n_o <= !(st_d == dpsem_pkg::ST_PULSE);
			data_oe_o <= (st_d == dpsem_pkg::ST_PULSE);
			addr_o <= addr_d;
			data_o <= wdata_d;
		end
	end

	// ----------------------------------------
	// Response and slave-mode busy drive
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= 18'h00000;
			rsp_contention_o <= 1'b0;
		end
		else if (en_i)
		begin
			rsp_valid_o <= (st_q == dpsem_pkg::ST_RECOVER) && init_done_q;
			if (st_q == dpsem_pkg::ST_SETUP && !is_wr && cnt_q == 4'(dpsem_pkg::RD_CYC - 1))
				rsp_rdata_o <= data_s;
			if (st_q == dpsem_pkg::ST_RECOVER)
				rsp_contention_o <= cont_q;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			contention_flag_o <= '1;
			contention_flag_oe_o <= '0;
		end
		else if (en_i)
		begin
			contention_flag_o <= {NBUSY{~block_writes_i}};
			contention_flag_oe_o <= {NBUSY{slave_mode_i}};
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_sem_ce;
		@(posedge clk_i) disable iff (!rst_n_i)
		!token_space_select_n_o |-> ce_n_o && oe_n_o == kind_q[0];
	endproperty
	a_sem_ce: assert property (p_sem_ce) else $error("chip enable low in token access");

	property p_slave_drive;
		@(posedge clk_i) disable iff (!rst_n_i)
		en_i && slave_mode_i && !block_writes_i |=> contention_flag_oe_o == '1
			&& contention_flag_o == '1;
	endproperty
	a_slave_drive: assert property (p_slave_drive) else $error("slave busy not held high");

	property p_pulse_ok;
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(rw_n_o) |-> $past(busy_ok) && data_oe_o;
	endproperty
	a_pulse_ok: assert property (p_pulse_ok) else $error("write pulse started while busy");

	property p_pulse_len;
		@(posedge clk_i) disable iff (!rst_n_i || !en_i)
		$fell(rw_n_o) |-> !rw_n_o [*3] ##1 rw_n_o;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("write pulse length wrong");

	property p_stall_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		en_i && st_q == dpsem_pkg::ST_STALL && !busy_all |=> st_q == dpsem_pkg::ST_STALL
			&& rw_n_o;
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stall left while busy low");

	property p_init_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(init_done_q) |-> $past(addr_o, 2) == OWN_MBX && !$past(oe_n_o, 2)
			&& !$past(ce_n_o, 2);
	endproperty
	a_init_clear: assert property (p_init_clear) else $error("own mailbox not cleared");

	c_mem_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(rw_n_o) && !ce_n_o);
	c_sem_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(rw_n_o) && !token_space_select_n_o);
	c_stall: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		st_q == dpsem_pkg::ST_STALL ##1 st_q == dpsem_pkg::ST_HOLD);
	c_irq: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(mbx_irq_o));
endmodule // dpsem_ctrl
`default_nettype wire

// ===== tb/dpsem_dev_model.sv
// Behavioural model of the dual-port device: memory, busy, mailbox flags, semaphores
`timescale 1ns/1ps
`default_nettype none
module dpsem_dev_model (
	input wire logic clk_i,
	input wire logic master_i,
	input wire logic [1:0] ce_n_i,
	input wire logic [1:0] rw_n_i,
	input wire logic [1:0] oe_n_i,
	input wire logic [1:0] sem_n_i,
	input wire logic [1:0][12:0] addr_i,
	input wire logic [1:0][17:0] data_i,
	input wire logic [1:0] busy_n_i,
	output logic [1:0][17:0] data_o,
	output logic [1:0] busy_n_o,
	output logic [1:0] int_n_o
);
	// ----------------------------------------
	// Port logic, index 0 left and 1 right
	// ----------------------------------------
	logic [17:0] mem [0:8191];
	logic [7:0] own [2];
	logic [7:0] req [2];
	logic [1:0][12:0] wa;
	logic [1:0][17:0] wd, sv;
	logic [1:0][13:0] pv;
	logic [1:0] wr_q, ws_q, inh_q, sr_q, bz;
	initial
	begin
		own = '{default: 8'h00};
		req = '{default: 8'h00};
		{wr_q, ws_q, inh_q, sr_q, bz} = 10'h000;
		data_o = '0;
		// Power-up flags left asserted so the host must clear them
		int_n_o = 2'b00;
	end
	always @(posedge clk_i)
	begin
		for (int p = 0; p < 2; p++)
		begin
			automatic int o = 1 - p;
			automatic logic [2:0] s = wa[p][2:0];
			automatic logic wr = !rw_n_i[p] && (!ce_n_i[p] || !sem_n_i[p]);
			automatic logic rs = !sem_n_i[p] && ce_n_i[p] && !oe_n_i[p] && rw_n_i[p];
			automatic logic [17:0] v = {18{!own[p][addr_i[p][2:0]]}};
			wr_q[p] <= wr;
			if (wr)
			begin
				wa[p] <= addr_i[p];
				wd[p] <= data_i[p];
				ws_q[p] <= ce_n_i[p];
				if (!busy_n_i[p])
					inh_q[p] <= 1'b1;
			end
			if (wr_q[p] && !wr)
			begin
				inh_q[p] <= 1'b0;
				if (ws_q[p])
				begin
					if (!wd[p][0])
					begin
						if (!own[o][s])
							own[p][s] <= 1'b1;
						else
							req[p][s] <= 1'b1;
					end
					else
					begin
						req[p][s] <= 1'b0;
						own[p][s] <= 1'b0;
						if (own[p][s] && req[o][s])
						begin
							own[o][s] <= 1'b1;
							req[o][s] <= 1'b0;
						end
					end
				end
				else if (!inh_q[p])
				begin
					mem[wa[p]] <= wd[p];
					if (wa[p] == (p ? 13'h1ffe : 13'h1fff))
						int_n_o[o] <= 1'b0;
				end
			end
			if (!ce_n_i[p] && !oe_n_i[p] && addr_i[p] == (p ? 13'h1fff : 13'h1ffe) && busy_n_i[p])
				int_n_o[p] <= 1'b1;
			if (!ce_n_i[p] && !oe_n_i[p] && rw_n_i[p])
				data_o[p] <= mem[addr_i[p]];
			else if (rs)
				data_o[p] <= sr_q[p] ? sv[p] : v;
			else
				data_o[p] <= ~data_o[p];
			if (rs && !sr_q[p])
				sv[p] <= v;
			sr_q[p] <= rs;
		end
		pv <= {ce_n_i[1], addr_i[1], ce_n_i[0], addr_i[0]};
		if (!master_i || ce_n_i != 2'b00 || addr_i[0] != addr_i[1])
			bz <= 2'b00;
		else if (bz == 2'b00)
			bz <= (pv[1] == {ce_n_i[1], addr_i[1]}) ? 2'b01 : 2'b10;
	end
	assign busy_n_o = ~bz;
endmodule // dpsem_dev_model
`default_nettype wire

// ===== tb/test_dpsem_ctrl.sv
// Self-checking bench of the host controller against the device model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_dpsem_ctrl;
	// ----------------------------------------
	// Stimulus, wiring and scenarios
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic slv = 1'b0, blk = 1'b0, cv = 1'b0;
	logic [1:0] ck = 2'h0;
	logic [12:0] ca = 13'h0000, ra = 13'h0000, la;
	logic [17:0] cd = 18'h00000, rd = 18'h00000, rq, dout, q;
	logic rce = 1'b1, rrw = 1'b1, roe = 1'b1, rsem = 1'b1;
	logic rdy, rv, rcon, irq, ce_n, rw_n, oe_n, sem_n, doe, bo, boe;
	logic [1:0][17:0] md;
	logic [1:0] mbz, mint;
	int n_mismatch = 0, num_checks = 0, cyc = 0;
	wire logic [17:0] dl = doe ? dout : md[0];
	wire logic bl = boe ? bo : mbz[0];
	// Busy input of the right port held high in slave mode
	wire logic br = slv | mbz[1];
	always #2.5 clk_i = ~clk_i;
	dpsem_ctrl dpsem_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(1'b1),
		.slave_mode_i(slv), .block_writes_i(blk), .cmd_valid_i(cv), .cmd_ready_o(rdy),
		.cmd_kind_i(ck), .cmd_addr_i(ca), .cmd_wdata_i(cd), .rsp_valid_o(rv),
		.rsp_rdata_o(rq), .rsp_contention_o(rcon), .mbx_irq_o(irq), .ce_n_o(ce_n),
		.rw_n_o(rw_n), .oe_n_o(oe_n), .token_space_select_n_o(sem_n), .addr_o(la),
		.data_i(dl), .data_o(dout), .data_oe_o(doe), .contention_flag_i(bl),
		.contention_flag_o(bo), .contention_flag_oe_o(boe), .mailbox_irq_n_i(mint[0]));
	dpsem_dev_model dpsem_dev_model_inst (.clk_i(clk_i), .master_i(!slv),
		.ce_n_i({rce, ce_n}), .rw_n_i({rrw, rw_n}), .oe_n_i({roe, oe_n}),
		.sem_n_i({rsem, sem_n}), .addr_i({ra, la}), .data_i({rd, dl}),
		.busy_n_i({br, bl}), .data_o(md), .busy_n_o(mbz), .int_n_o(mint));
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic go(input logic [1:0] k, input logic [12:0] a, input logic [17:0] d);
		int n = 0;
		@(negedge clk_i);
		while (rdy !== 1'b1 && n < 200)
		begin
			@(negedge clk_i);
			n++;
		end
		ck = k;
		ca = a;
		cd = d;
		cv = 1'b1;
		@(negedge clk_i);
		cv = 1'b0;
	endtask
	task automatic fin();
		int n = 0;
		while (rv !== 1'b1 && n < 300)
		begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 300)
		begin
			n_mismatch++;
			$display("[FAIL] %0t no answer", $time);
		end
	endtask
	task automatic cmd(input logic [1:0] k, input logic [12:0] a, input logic [17:0] d);
		go(k, a, d);
		fin();
	endtask
	task automatic racc(input logic s, input logic w, input logic [12:0] a,
		input logic [17:0] d, output logic [17:0] r);
		@(negedge clk_i);
		rce = s;
		rsem = !s;
		ra = a;
		rd = d;
		roe = w;
		rrw = !w;
		repeat (4) @(negedge clk_i);
		r = md[1];
		{rce, rsem, roe, rrw} = 4'hf;
		repeat (2) @(negedge clk_i);
	endtask
	task automatic t_init();
		repeat (40) @(negedge clk_i);
		`CHK(mint[0], 1'b1)
		`CHK(irq, 1'b0)
		// Right processor clears its own flag too
		racc(1'b0, 1'b0, 13'h1fff, 18'h00000, q);
		`CHK(mint[1], 1'b1)
	endtask
	task automatic t_mbx();
		racc(1'b0, 1'b1, 13'h1ffe, 18'h2a5c3, q);
		repeat (20) @(negedge clk_i);
		`CHK(irq, 1'b1)
		cmd(dpsem_pkg::CMD_MEM_RD, 13'h1ffe, 18'h00000);
		`CHK(rq, 18'h2a5c3)
		repeat (20) @(negedge clk_i);
		`CHK(irq, 1'b0)
		cmd(dpsem_pkg::CMD_MEM_WR, 13'h1fff, 18'h15a3c);
		`CHK(rcon, 1'b0)
		`CHK(mint[1], 1'b0)
		racc(1'b0, 1'b0, 13'h1fff, 18'h00000, q);
		`CHK(q, 18'h15a3c)
		`CHK(mint[1], 1'b1)
	endtask
	task automatic t_sem();
		cmd(dpsem_pkg::CMD_SEM_WR, 13'h1ff5, 18'h00000);
		cmd(dpsem_pkg::CMD_SEM_RD, 13'h0005, 18'h00000);
		`CHK(rq, 18'h00000)
		racc(1'b1, 1'b0, 13'h0005, 18'h00000, q);
		`CHK(q, 18'h3ffff)
		racc(1'b1, 1'b1, 13'h0005, 18'h00000, q);
		cmd(dpsem_pkg::CMD_SEM_RD, 13'h0005, 18'h00000);
		`CHK(rq, 18'h00000)
		cmd(dpsem_pkg::CMD_SEM_WR, 13'h0005, 18'h00001);
		cmd(dpsem_pkg::CMD_SEM_RD, 13'h0005, 18'h00000);
		`CHK(rq, 18'h3ffff)
		racc(1'b1, 1'b0, 13'h0005, 18'h00000, q);
		`CHK(q, 18'h00000)
		racc(1'b1, 1'b1, 13'h0005, 18'h00001, q);
		racc(1'b1, 1'b0, 13'h0005, 18'h00000, q);
		`CHK(q, 18'h3ffff)
		cmd(dpsem_pkg::CMD_SEM_RD, 13'h0005, 18'h00000);
		`CHK(rq, 18'h3ffff)
	endtask
	task automatic t_busy();
		@(negedge clk_i);
		ra = 13'h0100;
		rce = 1'b0;
		go(dpsem_pkg::CMD_MEM_WR, 13'h0100, 18'h01234);
		repeat (40) @(negedge clk_i);
		`CHK({ce_n, rw_n}, 2'b01)
		rce = 1'b1;
		fin();
		`CHK(rcon, 1'b1)
		cmd(dpsem_pkg::CMD_MEM_RD, 13'h0100, 18'h00000);
		`CHK(rq, 18'h01234)
	endtask
	task automatic t_slave();
		cmd(dpsem_pkg::CMD_MEM_WR, 13'h0300, 18'h3aaaa);
		slv = 1'b1;
		blk = 1'b1;
		repeat (10) @(negedge clk_i);
		`CHK({boe, bo}, 2'b10)
		cmd(dpsem_pkg::CMD_MEM_WR, 13'h0300, 18'h00055);
		cmd(dpsem_pkg::CMD_MEM_RD, 13'h0300, 18'h00000);
		`CHK(rq, 18'h3aaaa)
		blk = 1'b0;
		repeat (10) @(negedge clk_i);
		`CHK(bo, 1'b1)
		cmd(dpsem_pkg::CMD_MEM_WR, 13'h0300, 18'h00055);
		cmd(dpsem_pkg::CMD_MEM_RD, 13'h0300, 18'h00000);
		`CHK(rq, 18'h00055)
	endtask
	initial
	begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_init();
		t_mbx();
		t_sem();
		t_busy();
		t_slave();
		summarize();
	end
endmodule // test_dpsem_ctrl
`default_nettype wire
